// ### logic/cmm_consts.svh
// Constants of the message-object manager: sizes, register indices, field bits, bit timing
`ifndef CMM_CONSTS_SVH
`define CMM_CONSTS_SVH

`define CMM_NUM_OBJ      15
`define CMM_LAST_OBJ     4'hE
`define CMM_MAX_DLC      4'h8
`define CMM_STD_W        11
`define CMM_EXT_W        29

`define CMM_IDX_GM_STD   10'h006
`define CMM_IDX_GM_EXT   10'h008
`define CMM_IDX_OBJ_SEL  10'h010
`define CMM_IDX_OBJ_CFG  10'h011
`define CMM_IDX_OBJ_ID   10'h012
`define CMM_IDX_DATA_LO  10'h013
`define CMM_IDX_DATA_HI  10'h014
`define CMM_IDX_DLC      10'h015
`define CMM_IDX_CMD      10'h016
`define CMM_IDX_RX_ID    10'h017
`define CMM_IDX_BITCYC   10'h020
`define CMM_IDX_INT_ID   10'h05F

`define CMM_CFG_EXT      2
`define CMM_CFG_IE       3
`define CMM_CMD_TXREQ    0
`define CMM_CMD_CLRNEW   1

`define CMM_CLK_HZ       20000000
`define CMM_HS_HZ        1000000
`define CMM_LS_HZ        125000
`define CMM_BITCYC_HS    (`CMM_CLK_HZ / `CMM_HS_HZ)
`define CMM_BITCYC_LS    (`CMM_CLK_HZ / `CMM_LS_HZ)

`endif

// ### logic/cmm_obj_ram.sv
// Message-object storage: one write port, two registered read ports
`timescale 1ns/100ps
module cmm_obj_ram
   import cmm_pkg::*;
(
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   input  wire logic          we_i,
   input  wire logic [3:0]    waddr_i,
   input  wire cmm_frame_type wdata_i,
   input  wire logic [3:0]    raddr_a_i,
   output cmm_frame_type      rdata_a_o,
   input  wire logic [3:0]    raddr_b_i,
   output cmm_frame_type      rdata_b_o
);

   cmm_frame_type mem [0:15];

   always_ff @(posedge mclk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      if (rst_i)
      begin
         rdata_a_o <= '0;
         rdata_b_o <= '0;
      end
      else
      begin
         rdata_a_o <= mem[raddr_a_i];
         rdata_b_o <= mem[raddr_b_i];
      end
   end

endmodule : cmm_obj_ram

// ### logic/cmm_pkg.sv
// Types of the message-object manager
package cmm_pkg;

   typedef enum logic [1:0] {
      CMM_UNCONF = 2'h0,
      CMM_TX     = 2'h1,
      CMM_RX     = 2'h2
   } cmm_mode_type;

   typedef enum logic [1:0] {
      CMM_IDLE  = 2'h0,
      CMM_FETCH = 2'h1,
      CMM_LOAD  = 2'h3,
      CMM_SEND  = 2'h2
   } cmm_txst_type;

   typedef struct packed {
      logic        ext;
      logic [28:0] id;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cmm_frame_type;

   typedef struct packed {
      logic [14:0][1:0]  mode;
      logic [14:0]       ext;
      logic [14:0]       ie;
      logic [14:0][28:0] id;
      logic [14:0]       newdat;
      logic [14:0]       lost;
      logic [14:0]       txpend;
      logic              head15;
      logic [1:0]        cnt15;
      logic [10:0]       gm_std;
      logic [28:0]       gm_ext;
      logic [3:0]        sel;
      logic [63:0]       st_data;
      logic [3:0]        st_dlc;
      logic [15:0]       bitcyc;
      cmm_txst_type      txst;
      logic [3:0]        txcur;
      cmm_frame_type     txout;
      logic              txvalid;
      logic [31:0]       prdata;
   } cmm_state_type;

endpackage : cmm_pkg

// ### logic/cmm_top.sv
// Message-object manager: APB registers, acceptance filter, object store, transmit scheduler
// How it works
// (RULE_01) Fifteen objects; object fifteen receives only
// (RULE_02) Objects start unconfigured after reset
// (RULE_03) Standard 11-bit and extended 29-bit identifiers
// (RULE_04) Payload at most eight bytes per frame
// (RULE_05) Host moves eight bytes plus count
// (RULE_06) Host configures transmitter, loads, then requests
// (RULE_07) Request copies payload, sends when bus free
// (RULE_08) Matching frames stored in receive objects
// (RULE_09) Overwrite of unread data sets lost flag
// (RULE_10) Object fifteen buffers two frames
// (RULE_11) Only mask-one bit positions are compared
// (RULE_12) All compared bits equal means delivery
// (RULE_13) Global mask at locations six to nine
// (RULE_14) Masked low bits accepted by one object
// (RULE_15) Bit rate up to 1 MHz, low-speed 125 kHz
// (RULE_16) Receive in enabled object raises interrupt
// (RULE_17) Interrupt register names object, else zero
// (RULE_18) Clearing flag updates register, no extra interrupt
// (RULE_19) Reset selects 1 MHz bit timing; with LOW_SPEED set the code loads 160 cycles, 125 kHz
// (RULE_20) Lowest-numbered matching object wins
// (RULE_21) Request to non-transmitter is ignored
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "cmm_consts.svh"
module cmm_top
   import cmm_pkg::*;
#(
   parameter bit LOW_SPEED = 1'b0
)
(
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [11:0]   paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output logic [31:0]        prdata_o,
   output logic               pready_o,
   output logic               pslverr_o,
   input  wire logic          rx_valid_i,
   input  wire cmm_frame_type rx_frame_i,
   output logic               tx_valid_o,
   output cmm_frame_type      tx_frame_o,
   input  wire logic          tx_ready_i,
   output logic               irq_o,
   output logic [15:0]        bit_cycles_o
);

   localparam logic [15:0] BITCYC_MIN = LOW_SPEED ? 16'(`CMM_BITCYC_LS) : 16'(`CMM_BITCYC_HS);
   cmm_state_type s_q;
   cmm_state_type s_d;
   cmm_frame_type ram_a;
   cmm_frame_type ram_b;
   cmm_frame_type wr_data;
   logic          wr_en;
   logic [3:0]    wr_addr;
   logic [3:0]    rd_addr_a;
   logic [3:0]    oi;
   logic          sel_ok;
   logic [9:0]    idx;
   logic          acc;
   logic          setup;
   logic          mapped;
   logic [28:0]   cmp_mask;
   logic          hit;
   logic [3:0]    hit_idx;
   logic          rx_store;
   logic          stall;
   logic [7:0]    int_id;
   logic          tx_hit;
   logic [3:0]    tx_idx;
   logic [31:0]   rd;
   logic [1:0]    new_mode;
   logic [3:0]    clamp_dlc;

   assign idx    = paddr_i[11:2];
   assign acc    = psel_i & penable_i;
   assign setup  = psel_i & ~penable_i;
   assign oi     = s_q.sel - 4'h1;
   assign sel_ok = (s_q.sel != 4'h0);
   assign mapped = (idx == `CMM_IDX_GM_STD) || (idx == `CMM_IDX_GM_EXT)
                || ((idx >= `CMM_IDX_OBJ_SEL) && (idx <= `CMM_IDX_RX_ID))
                || (idx == `CMM_IDX_BITCYC) || (idx == `CMM_IDX_INT_ID);
   // Extended frames are masked by the 29-bit global mask, standard ones by the 11-bit one
   assign cmp_mask = rx_frame_i.ext ? s_q.gm_ext : 29'(s_q.gm_std); // see (RULE_03) (RULE_13)
   // Reading object fifteen shows its older buffered frame
   assign rd_addr_a = (oi == `CMM_LAST_OBJ) ? (`CMM_LAST_OBJ + {3'h0, s_q.head15}) : oi;
   assign clamp_dlc = (rx_frame_i.dlc > `CMM_MAX_DLC) ? `CMM_MAX_DLC : rx_frame_i.dlc;

   always_comb
   begin
      hit     = 1'b0;
      hit_idx = 4'h0;
      tx_hit  = 1'b0;
      tx_idx  = 4'h0;
      int_id  = 8'h00;
      // Scanning downward leaves the lowest match standing
      for (int i = `CMM_NUM_OBJ - 1; i >= 0; i--)
      begin
         if ((s_q.mode[i] == CMM_RX) && (s_q.ext[i] == rx_frame_i.ext)
             && (((rx_frame_i.id ^ s_q.id[i]) & cmp_mask) == 29'h0)) // see (RULE_11) (RULE_12) (RULE_14)
         begin
            hit     = 1'b1;
            hit_idx = 4'(i); // see (RULE_20)
         end
         if (s_q.txpend[i])
         begin
            tx_hit = 1'b1;
            tx_idx = 4'(i);
         end
         if (s_q.newdat[i] && s_q.ie[i])
         begin
            int_id = 8'(i + 1); // see (RULE_17)
         end
      end
   end

   assign rx_store = rx_valid_i & hit;
   // The single write port is busy with a receive; the copy waits one cycle
   assign stall    = acc & pwrite_i & (idx == `CMM_IDX_CMD) & pwdata_i[`CMM_CMD_TXREQ] & rx_store;

   always_comb
   begin
      s_d      = s_q;
      wr_en    = 1'b0;
      wr_addr  = 4'h0;
      wr_data  = '0;
      new_mode = 2'h0;
      rd       = 32'h0;

      // Read data is captured in the setup cycle so the access phase has no wait state
      if (setup)
      begin
         if (idx == `CMM_IDX_GM_STD) rd = 32'(s_q.gm_std);
         else if (idx == `CMM_IDX_GM_EXT) rd = 32'(s_q.gm_ext);
         else if (idx == `CMM_IDX_OBJ_SEL) rd = 32'(s_q.sel);
         else if (idx == `CMM_IDX_OBJ_CFG && sel_ok)
            rd = 32'({s_q.ie[oi], s_q.ext[oi], s_q.mode[oi]});
         else if (idx == `CMM_IDX_OBJ_ID && sel_ok) rd = 32'(s_q.id[oi]);
         else if (idx == `CMM_IDX_DATA_LO && sel_ok) rd = ram_a.data[31:0]; // see (RULE_05)
         else if (idx == `CMM_IDX_DATA_HI && sel_ok) rd = ram_a.data[63:32];
         else if (idx == `CMM_IDX_DLC && sel_ok) rd = 32'(ram_a.dlc);
         else if (idx == `CMM_IDX_CMD && sel_ok)
            rd = 32'({s_q.lost[oi], s_q.newdat[oi], s_q.txpend[oi]}); // see (RULE_09)
         else if (idx == `CMM_IDX_RX_ID && sel_ok) rd = 32'(ram_a.id); // see (RULE_08)
         else if (idx == `CMM_IDX_BITCYC) rd = 32'(s_q.bitcyc);
         else if (idx == `CMM_IDX_INT_ID) rd = 32'(int_id);
         s_d.prdata = rd;
      end

      // Host writes; clears come before receive sets so a set in the same cycle wins
      if (acc && pwrite_i && !stall)
      begin
         if (idx == `CMM_IDX_GM_STD) s_d.gm_std = pwdata_i[`CMM_STD_W-1:0]; // see (RULE_13)
         else if (idx == `CMM_IDX_GM_EXT) s_d.gm_ext = pwdata_i[`CMM_EXT_W-1:0];
         else if (idx == `CMM_IDX_OBJ_SEL) s_d.sel = pwdata_i[3:0];
         else if (idx == `CMM_IDX_OBJ_CFG && sel_ok)
         begin
            new_mode = pwdata_i[1:0];
            if ((new_mode == 2'h3) || ((oi == `CMM_LAST_OBJ) && (new_mode == CMM_TX)))
               new_mode = CMM_UNCONF; // see (RULE_01)
            s_d.mode[oi] = new_mode;
            s_d.ext[oi]  = pwdata_i[`CMM_CFG_EXT];
            s_d.ie[oi]   = pwdata_i[`CMM_CFG_IE];
         end
         else if (idx == `CMM_IDX_OBJ_ID && sel_ok)
            s_d.id[oi] = s_q.ext[oi] ? pwdata_i[`CMM_EXT_W-1:0]
                                     : 29'(pwdata_i[`CMM_STD_W-1:0]); // see (RULE_03)
         else if (idx == `CMM_IDX_DATA_LO) s_d.st_data[31:0] = pwdata_i;
         else if (idx == `CMM_IDX_DATA_HI) s_d.st_data[63:32] = pwdata_i;
         else if (idx == `CMM_IDX_DLC)
            s_d.st_dlc = (pwdata_i[3:0] > `CMM_MAX_DLC) ? `CMM_MAX_DLC : pwdata_i[3:0]; // see (RULE_04)
         else if (idx == `CMM_IDX_BITCYC)
            s_d.bitcyc = (pwdata_i[15:0] < BITCYC_MIN) ? BITCYC_MIN : pwdata_i[15:0]; // see (RULE_15)
         else if (idx == `CMM_IDX_CMD && sel_ok)
         begin
            // A request counts only for a transmitter set up beforehand
            if (pwdata_i[`CMM_CMD_TXREQ] && (s_q.mode[oi] == CMM_TX)) // see (RULE_06) (RULE_21)
            begin
               wr_en   = 1'b1;
               wr_addr = oi;
               wr_data = {s_q.ext[oi], s_q.id[oi], s_q.st_dlc, s_q.st_data}; // see (RULE_07)
               s_d.txpend[oi] = 1'b1;
            end
            if (pwdata_i[`CMM_CMD_CLRNEW])
            begin
               s_d.lost[oi] = 1'b0;
               if (oi == `CMM_LAST_OBJ)
               begin
                  if (s_q.cnt15 != 2'h0)
                  begin
                     s_d.cnt15  = s_q.cnt15 - 2'h1;
                     s_d.head15 = ~s_q.head15;
                  end
                  s_d.newdat[oi] = (s_q.cnt15 > 2'h1); // see (RULE_10) (RULE_18)
               end
               else
                  s_d.newdat[oi] = 1'b0; // see (RULE_18)
            end
         end
      end

      // Receive store, after any pop of object fifteen in this cycle
      if (rx_store)
      begin
         wr_en   = 1'b1;
         wr_data = {rx_frame_i.ext, rx_frame_i.id, clamp_dlc, rx_frame_i.data}; // see (RULE_04)
         if (hit_idx == `CMM_LAST_OBJ)
         begin
            if (s_d.cnt15 == 2'h2)
            begin
               // Both buffers full: the newer one is overwritten
               wr_addr       = `CMM_LAST_OBJ + {3'h0, ~s_d.head15};
               s_d.lost[hit_idx] = 1'b1; // see (RULE_09) (RULE_10)
            end
            else
            begin
               wr_addr   = `CMM_LAST_OBJ + {3'h0, s_d.head15 ^ s_d.cnt15[0]};
               s_d.cnt15 = s_d.cnt15 + 2'h1; // see (RULE_10)
            end
         end
         else
         begin
            wr_addr = hit_idx;
            if (s_d.newdat[hit_idx])
               s_d.lost[hit_idx] = 1'b1; // see (RULE_09)
         end
         s_d.newdat[hit_idx] = 1'b1; // see (RULE_08) (RULE_16)
      end

      // Transmit scheduler, lowest pending object first
      case (s_q.txst)
         CMM_IDLE:
         begin
            if (tx_hit)
            begin
               s_d.txcur = tx_idx;
               s_d.txst  = CMM_FETCH;
            end
         end
         CMM_FETCH:
            s_d.txst = CMM_LOAD;
         CMM_LOAD:
         begin
            s_d.txout   = ram_b; // see (RULE_07)
            s_d.txvalid = 1'b1;
            s_d.txst    = CMM_SEND;
         end
         CMM_SEND:
         begin
            if (tx_ready_i)
            begin
               s_d.txvalid = 1'b0;
               s_d.txst    = CMM_IDLE;
               // A fresh request for the same object in this cycle is kept
               if (!(wr_en && !rx_store && (wr_addr == s_q.txcur)))
                  s_d.txpend[s_q.txcur] = 1'b0;
            end
         end
         default:
            s_d.txst = CMM_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         s_q        <= '0; // see (RULE_02)
         s_q.bitcyc <= BITCYC_MIN; // see (RULE_19)
         s_q.txst   <= CMM_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   cmm_obj_ram u_ram (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .we_i      (wr_en),
      .waddr_i   (wr_addr),
      .wdata_i   (wr_data),
      .raddr_a_i (rd_addr_a),
      .rdata_a_o (ram_a),
      .raddr_b_i (s_q.txcur),
      .rdata_b_o (ram_b)
   );

   assign prdata_o     = s_q.prdata;
   assign pready_o     = ~stall;
   assign pslverr_o    = acc & ~mapped;
   assign tx_valid_o   = s_q.txvalid;
   assign tx_frame_o   = s_q.txout;
   assign irq_o        = (int_id != 8'h00); // see (RULE_16) (RULE_18)
   assign bit_cycles_o = s_q.bitcyc;

   obj15_rx_only_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_01)
      s_q.mode[`CMM_LAST_OBJ] != CMM_TX)
      else $error("object fifteen configured as transmitter");
   reset_defaults_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_02)
      $past(rst_i) |-> (s_q.mode == '0) && (bit_cycles_o == BITCYC_MIN) && !irq_o)
      else $error("state after reset not at defaults");
   rx_store_new_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_08)
      rx_store |=> s_q.newdat[$past(hit_idx)])
      else $error("matched frame not flagged as new");
   overwrite_lost_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_09)
      rx_store && (hit_idx != `CMM_LAST_OBJ) && s_q.newdat[hit_idx] |=> s_q.lost[$past(hit_idx)])
      else $error("overwrite without lost flag");
   dbl_buffer_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_10)
      rx_store && (hit_idx == `CMM_LAST_OBJ) && (s_q.cnt15 == 2'h0) && !s_q.lost[`CMM_LAST_OBJ]
      ##1 rx_store && (hit_idx == `CMM_LAST_OBJ) && !(acc && pwrite_i)
      |=> !s_q.lost[`CMM_LAST_OBJ] && (s_q.cnt15 == 2'h2))
      else $error("second frame in object fifteen lost");
   rate_floor_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_15)
      bit_cycles_o >= BITCYC_MIN)
      else $error("bit rate above allowed maximum");
   int_zero_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_17)
      ((s_q.newdat & s_q.ie) == 15'h0) |-> !irq_o)
      else $error("interrupt without pending object");
   int_raise_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_16)
      rx_store && s_q.ie[hit_idx] |=> irq_o)
      else $error("enabled receive did not interrupt");
   tx_ignore_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_21)
      acc && pwrite_i && (idx == `CMM_IDX_CMD) && sel_ok && (s_q.mode[oi] != CMM_TX)
      && !s_q.txpend[oi] && (s_q.txst == CMM_IDLE) |=> !s_q.txpend[$past(oi)] ##1 !tx_valid_o)
      else $error("request for non-transmitter started a send");
   tx_hold_a : assert property (@(posedge mclk_i) disable iff (rst_i) // see (RULE_07)
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o))
      else $error("transmit frame dropped before bus accepted it");

endmodule : cmm_top

// ### sim/cmm_bus_model.sv
// Bus-side partner: frame engine that takes transmit frames and injects received ones
`timescale 1ns/100ps
module cmm_bus_model
   import cmm_pkg::*;
(
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   input  wire logic [3:0]    stall_i,
   input  wire logic          tx_valid_i,
   input  wire cmm_frame_type tx_frame_i,
   output logic               tx_ready_o,
   output logic               rx_valid_o,
   output cmm_frame_type      rx_frame_o
);
   logic [3:0]    wait_q = '0;
   int            sent_count = 0;
   cmm_frame_type last_tx = '0;

   initial
   begin
      tx_ready_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_frame_o = '0;
   end

   // Bus busy for stall_i cycles before the frame can go out
   always @(posedge mclk_i)
   begin
      if (rst_i || !tx_valid_i)
      begin
         wait_q <= '0;
         tx_ready_o <= 1'b0;
      end
      else if (tx_ready_o)
      begin
         last_tx <= tx_frame_i;
         sent_count <= sent_count + 1;
         tx_ready_o <= 1'b0;
         wait_q <= '0;
      end
      else if (wait_q >= stall_i)
         tx_ready_o <= 1'b1;
      else
         wait_q <= wait_q + 4'h1;
   end

   task send_rx(input cmm_frame_type f);
      @(posedge mclk_i);
      rx_valid_o <= 1'b1;
      rx_frame_o <= f;
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      // Released lines must not keep showing the old frame
      rx_frame_o <= ~f;
   endtask : send_rx

   // Two frames on consecutive cycles, as a busy bus can deliver them
   task send_rx2(input cmm_frame_type f, input cmm_frame_type g);
      @(posedge mclk_i);
      rx_valid_o <= 1'b1;
      rx_frame_o <= f;
      @(posedge mclk_i);
      rx_frame_o <= g;
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      rx_frame_o <= ~g;
   endtask : send_rx2
endmodule : cmm_bus_model

// ### sim/test_cmm_top.sv
// Self-checking bench of the message-object manager
`timescale 1ns/100ps
`include "cmm_consts.svh"
module test_cmm_top
   import cmm_pkg::*;
;
   typedef struct packed {
      logic        wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } cmm_row_type;
   localparam logic [11:0] A_GMS = {`CMM_IDX_GM_STD, 2'b00};
   localparam logic [11:0] A_GME = {`CMM_IDX_GM_EXT, 2'b00};
   localparam logic [11:0] A_SEL = {`CMM_IDX_OBJ_SEL, 2'b00};
   localparam logic [11:0] A_CFG = {`CMM_IDX_OBJ_CFG, 2'b00};
   localparam logic [11:0] A_ID  = {`CMM_IDX_OBJ_ID, 2'b00};
   localparam logic [11:0] A_DLO = {`CMM_IDX_DATA_LO, 2'b00};
   localparam logic [11:0] A_DHI = {`CMM_IDX_DATA_HI, 2'b00};
   localparam logic [11:0] A_DLC = {`CMM_IDX_DLC, 2'b00};
   localparam logic [11:0] A_CMD = {`CMM_IDX_CMD, 2'b00};
   localparam logic [11:0] A_RID = {`CMM_IDX_RX_ID, 2'b00};
   localparam logic [11:0] A_BIT = {`CMM_IDX_BITCYC, 2'b00};
   localparam logic [11:0] A_INT = {`CMM_IDX_INT_ID, 2'b00};

   logic          mclk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          psel_i = 1'b0;
   logic          penable_i = 1'b0;
   logic          pwrite_i = 1'b0;
   logic [11:0]   paddr_i = '0;
   logic [31:0]   pwdata_i = '0;
   logic [31:0]   prdata_o;
   logic [31:0]   rd;
   logic          pready_o, pslverr_o, serr, rx_valid_i, tx_valid_o, tx_ready_i, irq_o;
   logic [15:0]   bit_cycles_o;
   logic [3:0]    stall = '0;
   cmm_frame_type rx_frame_i, tx_frame_o;
   int            bad_count = 0;
   int            n_checks = 0;
   int            n_waits = 0;
   int            cycles = 0;
   cmm_row_type   rows [7];

   cmm_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
      .rx_frame_i(rx_frame_i), .tx_valid_o(tx_valid_o), .tx_frame_o(tx_frame_o),
      .tx_ready_i(tx_ready_i), .irq_o(irq_o), .bit_cycles_o(bit_cycles_o));
   cmm_bus_model M (.mclk_i(mclk_i), .rst_i(rst_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
      .tx_frame_i(tx_frame_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
      .rx_frame_o(rx_frame_i));

   always #25 mclk_i = ~mclk_i;

   // Run should need well under 5000 cycles
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end

   // Wait states seen by the bench; only the request that meets a stored frame should cause one
   always @(posedge mclk_i)
   begin
      if (psel_i && penable_i && !pready_o)
         n_waits++;
   end

   task stop_test();
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task check(input logic [97:0] seen, input logic [97:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Request held until pready is sampled high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rdc

   task cfg(input logic [31:0] n, input logic [31:0] c, input logic [31:0] id);
      apb(1'b1, A_SEL, n);
      apb(1'b1, A_CFG, c);
      apb(1'b1, A_ID, id);
   endtask : cfg

   task wait_tx(input int n);
      for (int k = 0; k < 60 && M.sent_count < n; k++)
         @(posedge mclk_i);
   endtask : wait_tx

   function automatic cmm_frame_type fr(input logic e, input logic [28:0] id,
                                        input logic [3:0] n, input logic [63:0] d);
      fr = {e, id, n, d};
   endfunction : fr

   initial
   begin
      rows[0] = '{1'b1, A_GMS, 32'hFFFFFFFF, 32'h000007FF};
      rows[1] = '{1'b1, A_GME, 32'hFFFFFFFF, 32'h1FFFFFFF};
      rows[2] = '{1'b1, A_BIT, 32'h00000005, 32'h00000014};
      rows[3] = '{1'b1, A_BIT, 32'h00000064, 32'h00000064};
      rows[4] = '{1'b0, A_INT, 32'h00000000, 32'h00000000};
      rows[5] = '{1'b1, A_SEL, 32'h00000007, 32'h00000007};
      rows[6] = '{1'b1, 12'h3FC, 32'h00001234, 32'h00000000};
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(bit_cycles_o, 16'h0014);
      check({tx_valid_o, irq_o}, 2'b00);
      for (int i = 1; i <= 15; i++)
      begin
         apb(1'b1, A_SEL, i);
         rdc(A_CFG, 32'h0);
      end
      foreach (rows[i])
      begin
         if (rows[i].wr)
            apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         check(rd, rows[i].e);
      end
      check({serr, bit_cycles_o}, 17'h10064);
      // Receive, masking and lowest-object selection
      apb(1'b1, A_GMS, 32'h7FC);
      cfg(15, 32'h1, 32'h0);
      rdc(A_CFG, 32'h0);
      cfg(1, 32'h2, 32'h1);
      cfg(2, 32'h2, 32'h2);
      cfg(3, 32'hA, 32'h100);
      cfg(15, 32'hE, 32'h1FFFFFFF);
      M.send_rx(fr(1'b0, 29'h3, 4'h2, 64'hBBAA));
      apb(1'b1, A_SEL, 32'h1);
      rdc(A_CMD, 32'h2);
      rdc(A_RID, 32'h3);
      rdc(A_DLO, 32'hBBAA);
      rdc(A_DLC, 32'h2);
      apb(1'b1, A_SEL, 32'h2);
      rdc(A_CMD, 32'h0);
      M.send_rx(fr(1'b0, 29'h2, 4'h8, 64'h55));
      apb(1'b1, A_SEL, 32'h1);
      rdc(A_CMD, 32'h6);
      apb(1'b1, A_CMD, 32'h2);
      M.send_rx(fr(1'b0, 29'h4, 4'h1, 64'h0));
      rdc(A_CMD, 32'h0);
      // Interrupts and the two-deep object
      M.send_rx(fr(1'b0, 29'h102, 4'h1, 64'h7));
      // Back-to-back frames fill both buffers of object fifteen
      M.send_rx2(fr(1'b1, 29'h1FFFFFFF, 4'h4, 64'h1111),
                 fr(1'b1, 29'h1FFFFFFF, 4'h4, 64'h2222));
      #1;
      check(irq_o, 1'b1);
      rdc(A_INT, 32'h3);
      apb(1'b1, A_SEL, 32'h3);
      apb(1'b1, A_CMD, 32'h2);
      rdc(A_INT, 32'hF);
      apb(1'b1, A_SEL, 32'hF);
      rdc(A_CMD, 32'h2);
      rdc(A_DLO, 32'h1111);
      rdc(A_RID, 32'h1FFFFFFF);
      apb(1'b1, A_CMD, 32'h2);
      rdc(A_DLO, 32'h2222);
      rdc(A_CMD, 32'h2);
      apb(1'b1, A_CMD, 32'h2);
      rdc(A_INT, 32'h0);
      #1;
      check(irq_o, 1'b0);
      // Transmit with a busy bus, then an extended one, then a refused one
      cfg(4, 32'h1, 32'h123);
      apb(1'b1, A_DLO, 32'h44332211);
      apb(1'b1, A_DHI, 32'h88776655);
      apb(1'b1, A_DLC, 32'h9);
      stall <= 4'h6;
      apb(1'b1, A_CMD, 32'h1);
      wait_tx(1);
      check(M.last_tx, fr(1'b0, 29'h123, 4'h8, 64'h8877665544332211));
      rdc(A_RID, 32'h123);
      rdc(A_DLC, 32'h8);
      cfg(4, 32'h5, 32'h1FFFFFFF);
      stall <= 4'h0;
      apb(1'b1, A_CMD, 32'h1);
      wait_tx(2);
      check(M.last_tx, fr(1'b1, 29'h1FFFFFFF, 4'h8, 64'h8877665544332211));
      apb(1'b1, A_SEL, 32'h5);
      apb(1'b1, A_CMD, 32'h1);
      repeat (20) @(posedge mclk_i);
      check(M.sent_count, 2);
      // A request meeting a stored frame waits one cycle, then both land
      apb(1'b1, A_SEL, 32'h4);
      fork
         apb(1'b1, A_CMD, 32'h1);
         begin
            @(posedge mclk_i);
            M.send_rx(fr(1'b0, 29'h1, 4'h1, 64'h9));
         end
      join
      wait_tx(3);
      check(M.sent_count, 3);
      check(n_waits, 1);
      apb(1'b1, A_SEL, 32'h1);
      rdc(A_CMD, 32'h2);
      // Reset in mid-run returns objects and bit timing to defaults
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      apb(1'b1, A_SEL, 32'h1);
      rdc(A_CFG, 32'h0);
      rdc(A_CMD, 32'h0);
      rdc(A_BIT, 32'h14);
      stop_test();
   end
endmodule : test_cmm_top
